// >>> mmcs_pkg.sv
// constants and types shared by the management command block
// Behaviour
// - scan bit repeats reads until cleared
// - read bit runs one read, stores data
// - writing the write data register runs one write cycle
// - link fail bit mirrors phy status
// - read-data-invalid high while read outstanding
// - scanning bit shows scan under way
// - busy bit high during any cycle
// - byte accesses ignored, wider ones accepted
// - unimplemented bits read as zero
// - clear, set, invert aliases at +4,8,c
package mmcs_pkg;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD   = 8'h00; // mgmt_command
  localparam logic [7:0] OFS_IND   = 8'h10; // mgmt_indicators
  localparam logic [7:0] OFS_WDATA = 8'h20; // mgmt_write_data
  localparam logic [7:0] OFS_RDATA = 8'h30; // mgmt_read_data
  localparam logic [7:0] OFS_ADDR  = 8'h40; // phy and register address
  localparam logic [7:0] OFS_ISTAT = 8'h50; // interrupt status
  localparam logic [7:0] OFS_IMASK = 8'h60; // interrupt mask
  // alias selector in address bits 3:2
  localparam logic [1:0] AL_PLAIN = 2'h0;
  localparam logic [1:0] AL_CLR   = 2'h1;
  localparam logic [1:0] AL_SET   = 2'h2;
  localparam logic [1:0] AL_INV   = 2'h3;
  // access size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CMD_READ    = 0;
  localparam int CMD_SCAN    = 1;
  localparam int IND_BUSY    = 0;
  localparam int IND_SCAN    = 1;
  localparam int IND_PENDING = 2;
  localparam int IND_LINK    = 3;
  localparam int INT_DONE    = 0; // a cycle finished
  localparam int INT_LINK    = 1; // link flag changed
  localparam int ADDR_PHY    = 8; // phy address at 12:8
  localparam int STAT_LINKUP = 2; // link status in phy status
  localparam logic [4:0] PHY_STATUS_REG = 5'h01;
  // ----------------------------------------
  // frame layout, 64 bit times
  // ----------------------------------------
  localparam logic [6:0]  FRAME_BITS = 7'h40;
  localparam logic [6:0]  TA_BIT     = 7'h2e; // first turnaround bit
  localparam logic [6:0]  DATA_BIT   = 7'h30; // first data bit
  localparam logic [31:0] PREAMBLE   = 32'hffffffff;
  localparam logic [1:0]  FR_START   = 2'h1;
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  TA_WRITE   = 2'h2;
  // engine states
  typedef enum logic {ENG_IDLE, ENG_RUN} mmcs_eng_e;
endpackage

// >>> mmcs_frame_if.sv
// signals between the register side and the frame engine
interface mmcs_frame_if;
  logic        start;    // one-cycle frame request
  logic        isRead;   // frame kind
  logic [4:0]  phyAddr;  // target phy
  logic [4:0]  regAddr;  // target phy register
  logic [15:0] wrData;   // write payload
  logic [15:0] rdData;   // captured read payload
  logic        done;     // one-cycle end of frame
  logic        mdcRise;  // link clock rising edge
  logic        mdcFall;  // link clock falling edge
  logic        mdioIn;   // synchronised data line
  logic        mdioOut;  // driven data value
  logic        mdioOe;   // high while driving
  modport eng (input start, isRead, phyAddr, regAddr, wrData,
               mdcRise, mdcFall, mdioIn,
               output rdData, done, mdioOut, mdioOe);
  modport ctl (output start, isRead, phyAddr, regAddr, wrData,
               mdcRise, mdcFall, mdioIn,
               input rdData, done, mdioOut, mdioOe);
endinterface

// >>> mmcs_frame_engine.sv
// shifts one management frame out and captures read data
module mmcs_frame_engine
  import mmcs_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  mmcs_frame_if.eng  fr
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  mmcs_eng_e   state, next_state;     // idle or shifting
  logic [63:0] shiftReg, next_shiftReg; // frame bits, msb first
  logic [6:0]  bitCnt, next_bitCnt;   // bits driven so far
  logic [15:0] capReg, next_capReg;   // read data capture
  logic        isRd, next_isRd;       // frame is a read
  logic        outQ, next_outQ;       // data line value
  logic        oeQ, next_oeQ;         // data line enable
  logic        doneQ, next_doneQ;     // end pulse

  assign fr.rdData  = capReg;
  assign fr.done    = doneQ;
  assign fr.mdioOut = outQ;
  assign fr.mdioOe  = oeQ;

  // next-state logic for the frame
  always_comb begin
    next_state    = state;
    next_shiftReg = shiftReg;
    next_bitCnt   = bitCnt;
    next_capReg   = capReg;
    next_isRd     = isRd;
    next_outQ     = outQ;
    next_oeQ      = oeQ;
    next_doneQ    = 1'b0;
    case (state)
      ENG_IDLE: begin
        if (fr.start) begin
          // read frames carry a dummy payload; the phy drives it
          next_state    = ENG_RUN;
          next_isRd     = fr.isRead;
          next_bitCnt   = '0;
          next_shiftReg = {PREAMBLE, FR_START,
                           fr.isRead ? OP_READ : OP_WRITE,
                           fr.phyAddr, fr.regAddr, TA_WRITE,
                           fr.wrData};
        end
      end
      ENG_RUN: begin
        // drive on the falling edge so the phy sees stable data
        if (fr.mdcFall && bitCnt < FRAME_BITS) begin
          next_outQ     = shiftReg[63];
          next_shiftReg = {shiftReg[62:0], 1'b0};
          next_oeQ      = !(isRd && bitCnt >= TA_BIT);
          next_bitCnt   = bitCnt + 7'h01;
        end
        // sample the phy's bits on the rising edge
        if (fr.mdcRise && isRd && bitCnt > DATA_BIT)
          next_capReg = {capReg[14:0], fr.mdioIn};
        // frame complete after the last rising edge
        if (fr.mdcRise && bitCnt == FRAME_BITS) begin
          next_state = ENG_IDLE;
          next_doneQ = 1'b1;
          next_oeQ   = 1'b0;
        end
      end
      default: next_state = ENG_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= ENG_IDLE;
      shiftReg <= '0;
      bitCnt   <= '0;
      capReg   <= '0;
      isRd     <= 1'b0;
      outQ     <= 1'b0;
      oeQ      <= 1'b0;
      doneQ    <= 1'b0;
    end else begin
      state    <= next_state;
      shiftReg <= next_shiftReg;
      bitCnt   <= next_bitCnt;
      capReg   <= next_capReg;
      isRd     <= next_isRd;
      outQ     <= next_outQ;
      oeQ      <= next_oeQ;
      doneQ    <= next_doneQ;
    end
  end
endmodule

// >>> mmcs_top.sv
// management command and status block with register port
module mmcs_top
  import mmcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [1:0]  regSize,
  output      logic [31:0] regRdata,
  input  wire logic        mdcIn,
  input  wire logic        mdioIn,
  output      logic        mdioOut,
  output      logic        mdioOe,
  output      logic        irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // the engine talks through one bundle, so its port list stays short
  // and the frame fields cannot be wired to the wrong pins
  mmcs_frame_if fr ();

  logic        mdcS1, mdcS2, mdcS3;  // link clock sync and history
  logic        dioS1, dioS2;         // data line sync
  // software visible state and its next values
  logic        cmdRead, next_cmdRead; // command read bit
  logic        cmdScan, next_cmdScan; // command scan bit
  logic [15:0] wrData, next_wrData;  // write payload
  logic [15:0] rdData, next_rdData;  // last read result
  logic [4:0]  phyAd, next_phyAd;    // phy address
  logic [4:0]  regAd, next_regAd;    // phy register
  logic        busy, next_busy;      // a frame is running
  logic        pend, next_pend;      // read data not valid
  logic        scanning, next_scanning; // scan under way
  logic        linkDown, next_linkDown; // last link state
  logic        rdReq, next_rdReq;    // single read waiting
  logic        wrReq, next_wrReq;    // write waiting
  logic        opRead, next_opRead;  // running frame is a read
  logic        startQ, next_startQ;  // start pulse to engine
  logic [1:0]  intStat, next_intStat; // sticky events
  logic [1:0]  intMask, next_intMask; // event enables
  logic        irqQ, next_irqQ;      // interrupt line
  logic [31:0] rdataQ, next_rdataQ;  // read answer
  // combinational helpers, decoded fresh each cycle
  logic        wrOk;                 // accepted write
  logic        rdOk;                 // accepted read
  logic [7:0]  base;                 // register base address
  logic [1:0]  al;                   // alias selector
  logic [31:0] cmdNew;               // command after alias
  logic [31:0] gen;                  // generic reg after alias
  logic [1:0]  evSet;                // events this cycle
  logic        linkNew;              // link flag after a read

  // every alias write funnels through this one helper, so the
  // command, data, address and mask registers behave alike;
  // the clear form is what software uses to drop a bit safely
  // apply plain, clear, set or invert write
  function automatic logic [31:0] alias_apply(
    input logic [31:0] cur,
    input logic [31:0] wd,
    input logic [1:0]  sel
  );
    case (sel)
      AL_CLR:  alias_apply = cur & ~wd;
      AL_SET:  alias_apply = cur | wd;
      AL_INV:  alias_apply = cur ^ wd;
      default: alias_apply = wd;
    endcase
  endfunction

  // ----------------------------------------
  // link pin synchronisers
  // ----------------------------------------
  // the link clock is sampled, edges found after two flops
  // a third flop keeps the previous level so rise and fall can be
  // told apart; it only reads the second flop, never the first.
  // the link clock should run at a quarter of clk or slower, so
  // that each of its levels is seen for at least two cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      mdcS1 <= 1'b0;
      mdcS2 <= 1'b0;
      mdcS3 <= 1'b0;
      dioS1 <= 1'b0;
      dioS2 <= 1'b0;
    end else begin
      mdcS1 <= mdcIn;
      mdcS2 <= mdcS1;
      mdcS3 <= mdcS2;
      dioS1 <= mdioIn;
      dioS2 <= dioS1;
    end
  end

  // ----------------------------------------
  // engine hookup
  // ----------------------------------------
  // edges are single-cycle strobes on clk; the engine never sees
  // the raw link clock, which keeps the whole block on one clock
  assign fr.start   = startQ;
  assign fr.isRead  = opRead;
  assign fr.phyAddr = phyAd;
  assign fr.regAddr = regAd;
  assign fr.wrData  = wrData;
  assign fr.mdcRise = mdcS2 & ~mdcS3;
  assign fr.mdcFall = ~mdcS2 & mdcS3;
  assign fr.mdioIn  = dioS2;
  assign mdioOut    = fr.mdioOut;
  assign mdioOe     = fr.mdioOe;

  // the engine shifts one frame per start pulse and reports done
  mmcs_frame_engine u_eng (
    .clk (clk),
    .rst (rst),
    .fr  (fr.eng)
  );

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  // byte accesses vanish without effect or answer
  // the register is picked by bits 7:4 and the alias by bits 3:2;
  // bits 1:0 are ignored, so any byte lane address reaches the word
  assign wrOk = regWr && (regSize != SZ_BYTE);
  assign rdOk = regRd && (regSize != SZ_BYTE);
  assign base = {regAddr[7:4], 4'h0};
  assign al   = regAddr[3:2];
  assign cmdNew = alias_apply({30'h0, cmdScan, cmdRead},
                              regWdata, al);
  // the phy reports link up; the flag holds the inverse, link down
  assign linkNew = ~fr.rdData[STAT_LINKUP];

  // ----------------------------------------
  // control, command sequencing and flags
  // ----------------------------------------
  // one process owns all command state so that a software write and
  // a frame end landing in the same cycle resolve in a single place.
  // priority: frame end first, then queued write, single read, scan.
  // a limitation: a write queued during a scan waits for the scan
  // read in flight, so scan latency grows by one frame per write
  always_comb begin
    next_cmdRead  = cmdRead;
    next_cmdScan  = cmdScan;
    next_wrData   = wrData;
    next_rdData   = rdData;
    next_phyAd    = phyAd;
    next_regAd    = regAd;
    next_busy     = busy;
    next_pend     = pend;
    next_linkDown = linkDown;
    next_rdReq    = rdReq;
    next_wrReq    = wrReq;
    next_opRead   = opRead;
    next_startQ   = 1'b0;
    next_intMask  = intMask;
    next_irqQ     = 1'b0;
    evSet         = 2'h0;
    gen           = 32'h0;
    // software writes
    // byte writes never get here, the size check already refused them
    if (wrOk) begin
      case (base)
        OFS_CMD: begin
          next_cmdRead = cmdNew[CMD_READ];
          next_cmdScan = cmdNew[CMD_SCAN];
          // a fresh read bit queues one read
          if (cmdNew[CMD_READ] && !cmdRead)
            next_rdReq = 1'b1;
        end
        // writing the payload is what launches a write frame
        OFS_WDATA: begin
          gen         = alias_apply({16'h0, wrData}, regWdata, al);
          next_wrData = gen[15:0];
          next_wrReq  = 1'b1;
        end
        // phy address in 12:8, register in 4:0, the gap reads zero
        OFS_ADDR: begin
          gen        = alias_apply({19'h0, phyAd, 3'h0, regAd},
                                   regWdata, al);
          next_phyAd = gen[ADDR_PHY+:5];
          next_regAd = gen[4:0];
        end
        // mask bits only gate the interrupt line, never the status
        OFS_IMASK: begin
          gen          = alias_apply({30'h0, intMask}, regWdata, al);
          next_intMask = gen[1:0];
        end
        // indicators, read data and status are not written here
        default: ;
      endcase
    end
    // frame completion; data stored in the same edge flags drop
    // software polling busy can therefore never see stale read data
    if (fr.done) begin
      next_busy = 1'b0;
      next_pend = 1'b0;
      evSet[INT_DONE] = 1'b1;
      if (opRead) begin
        // a write frame leaves the last read result untouched
        next_rdData = fr.rdData;
        if (regAd == PHY_STATUS_REG) begin
          // only a read of the phy status register updates the flag
          next_linkDown = linkNew;
          evSet[INT_LINK] = (linkNew != linkDown);
        end
      end
    end else if (!busy) begin
      // writes first, then single reads, then scan reads
      // a new frame is launched only from the idle gap after done
      if (wrReq) begin
        next_wrReq  = 1'b0;
        next_busy   = 1'b1;
        next_opRead = 1'b0;
        next_startQ = 1'b1;
      end else if (rdReq || cmdScan) begin
        next_rdReq  = 1'b0;
        next_busy   = 1'b1;
        next_pend   = 1'b1;
        next_opRead = 1'b1;
        next_startQ = 1'b1;
      end
    end
    // scan stays reported until its last read ends
    // otherwise software could see scan off while a read still runs
    next_scanning = next_cmdScan | (scanning & next_busy & opRead);
    // sticky events, a set beats a same-cycle clear
    // so a frame ending in the very cycle of a clear is never lost;
    // aliases do not reach this register, only the plain address
    next_intStat = intStat;
    if (wrOk && base == OFS_ISTAT && al == AL_PLAIN)
      next_intStat = intStat & ~regWdata[1:0];
    next_intStat = next_intStat | evSet;
    next_irqQ = |(next_intStat & next_intMask);
  end

  // ----------------------------------------
  // read answer, one cycle after the strobe
  // ----------------------------------------
  // the answer is registered and cleared when no read is taken, so
  // the data lines carry zero between reads and nothing leaks out
  // of an unrelated register; reads have no side effects at all
  always_comb begin
    next_rdataQ = 32'h0;
    if (rdOk) begin
      case (base)
        OFS_CMD:   next_rdataQ = {30'h0, cmdScan, cmdRead};
        OFS_IND:   next_rdataQ = {28'h0, linkDown, pend,
                                  scanning, busy};
        OFS_WDATA: next_rdataQ = {16'h0, wrData};
        OFS_RDATA: next_rdataQ = {16'h0, rdData};
        OFS_ADDR:  next_rdataQ = {19'h0, phyAd, 3'h0, regAd};
        OFS_ISTAT: next_rdataQ = {30'h0, intStat};
        OFS_IMASK: next_rdataQ = {30'h0, intMask};
        default:   next_rdataQ = 32'h0; // unmapped reads zero
      endcase
    end
  end

  // all top outputs come straight from flops, no logic after them
  assign regRdata = rdataQ;
  assign irq      = irqQ;

  // ----------------------------------------
  // registers only
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      // everything starts idle with the link released
      cmdRead  <= 1'b0;
      cmdScan  <= 1'b0;
      wrData   <= 16'h0;
      rdData   <= 16'h0;
      phyAd    <= 5'h0;
      regAd    <= 5'h0;
      busy     <= 1'b0;
      pend     <= 1'b0;
      scanning <= 1'b0;
      linkDown <= 1'b0;
      rdReq    <= 1'b0;
      wrReq    <= 1'b0;
      opRead   <= 1'b0;
      startQ   <= 1'b0;
      intStat  <= 2'h0;
      intMask  <= 2'h0;
      irqQ     <= 1'b0;
      rdataQ   <= 32'h0;
    end else begin
      // plain register stage, all decisions are made above
      cmdRead  <= next_cmdRead;
      cmdScan  <= next_cmdScan;
      wrData   <= next_wrData;
      rdData   <= next_rdData;
      phyAd    <= next_phyAd;
      regAd    <= next_regAd;
      busy     <= next_busy;
      pend     <= next_pend;
      scanning <= next_scanning;
      linkDown <= next_linkDown;
      rdReq    <= next_rdReq;
      wrReq    <= next_wrReq;
      opRead   <= next_opRead;
      startQ   <= next_startQ;
      intStat  <= next_intStat;
      intMask  <= next_intMask;
      irqQ     <= next_irqQ;
      rdataQ   <= next_rdataQ;
    end
  end
endmodule

// >>> mmcs_checker.sv
// assertion checker on the management block ports
module mmcs_checker
  import mmcs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [1:0]  regSize,
  input wire logic [31:0] regRdata,
  input wire logic        mdioOut,
  input wire logic        mdioOe,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // shadow of the interrupt mask
  // ----
  logic [1:0] maskReg;      // mask as last written
  logic [1:0] next_maskReg; // its next value
  logic       rdWide;       // read that is not refused
  assign rdWide = regRd && regSize != SZ_BYTE;
  // plain wide writes only: the bench never uses mask aliases
  always_comb begin
    next_maskReg = maskReg;
    if (regWr && regSize != SZ_BYTE && regAddr == OFS_IMASK) begin
      next_maskReg = regWdata[1:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      maskReg <= 2'h0;
    end else begin
      maskReg <= next_maskReg;
    end
  end
  // ----
  // assertions
  // ----
  AST_RDATA_QUIET: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data present without a read");
  AST_CMD_UNIMPL: assert property ($past(rdWide && regAddr[7:4] == 4'h0) |->
    regRdata[31:2] == 30'h0) else $error("command upper bits not zero");
  AST_IND_UNIMPL: assert property ($past(rdWide && regAddr == OFS_IND) |->
    regRdata[31:4] == 28'h0) else $error("indicator upper bits not zero");
  AST_BYTE_READ: assert property ($past(regRd && regSize == SZ_BYTE) |->
    regRdata == 32'h0) else $error("byte read returned data");
  AST_BUSY_IN_FRAME: assert property ($past(rdWide && regAddr == OFS_IND && mdioOe)
    |-> regRdata[IND_BUSY]) else $error("busy low while driving a frame");
  AST_PEND_BUSY: assert property ($past(rdWide && regAddr == OFS_IND) |->
    (!regRdata[IND_PENDING] || regRdata[IND_BUSY])) else $error("pending without busy");
  AST_PREAMBLE: assert property ($rose(mdioOe) |-> ##2 (mdioOe && mdioOut)[*8])
    else $error("frame does not open with ones");
  AST_IRQ_MASKED: assert property (maskReg == 2'h0 |-> !irq)
    else $error("interrupt high with mask clear");
endmodule

bind mmcs_top mmcs_checker mmcs_checker_i (.clk, .rst, .regAddr, .regWdata, .regWr,
  .regRd, .regSize, .regRdata, .mdioOut, .mdioOe, .irq);

// >>> mmcs_phy_model.sv
// phy model answering management read and write frames
module mmcs_phy_model (
  input  wire logic run,    // link clock allowed to toggle
  input  wire logic mdio,   // resolved data line
  output      logic mdc,    // link clock
  output      logic phyOe,  // model drives the line
  output      logic phyOut  // value driven
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] regs [32]; // phy register file
  logic [15:0] sh;        // bits seen on rising edges
  logic [4:0]  ra;        // addressed register
  logic        isRd;      // frame kind
  int          bitCnt;    // zero while hunting a header
  int          rdCnt;     // read frames answered
  // 160 ns clock, parked low between frames
  initial begin
    mdc = 1'b0;
    phyOe = 1'b0;
    phyOut = 1'b0;
    sh = 16'h0;
    bitCnt = 0;
    rdCnt = 0;
    foreach (regs[i]) regs[i] = 16'h0;
    forever #80 mdc = run ? ~mdc : 1'b0;
  end
  // header hunt (ones, start, opcode) and write capture
  always @(posedge mdc) begin
    sh = {sh[14:0], mdio};
    if (bitCnt == 0 && (sh[15:10] == 6'h36 || sh[15:10] == 6'h35)) begin
      isRd = sh[11];
      ra = sh[4:0];
      bitCnt = 1;
    end else if (bitCnt > 0 && !isRd) begin
      bitCnt++;
      // two turnaround bits, then sixteen data bits
      if (bitCnt == 19) begin
        regs[ra] = sh;
        bitCnt = 0;
        sh = 16'h0;
      end
    end
  end
  // read answer: released, zero, then data msb first
  always @(negedge mdc) begin
    if (bitCnt > 0 && isRd) begin
      bitCnt++;
      phyOe = bitCnt >= 3 && bitCnt <= 19;
      phyOut = bitCnt == 3 ? 1'b0 : regs[ra][(19 - bitCnt) & 15];
      if (bitCnt == 20) begin
        rdCnt++;
        bitCnt = 0;
        sh = 16'h0;
      end
    end
  end
endmodule

// >>> test_mii_management_command_status.sv
// self-checking bench for the management command block
module test_mii_management_command_status
  import mmcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;       // 50 mhz clock
  logic        rst;       // synchronous reset
  logic [7:0]  regAddr;   // register address
  logic [31:0] regWdata;  // write data
  logic        regWr;     // write strobe
  logic        regRd;     // read strobe
  logic [1:0]  regSize;   // access size
  logic [31:0] regRdata;  // read data
  logic        mdc;       // link clock
  logic        mdio;      // resolved data line
  logic        mdioOut;   // block drive value
  logic        mdioOe;    // block drive enable
  logic        phyOe;     // model drive enable
  logic        phyOut;    // model drive value
  logic        irq;       // interrupt
  logic        run;       // lets the link clock run
  logic [31:0] v;         // last read value
  int          nMismatch; // failed comparisons
  int          nCompared; // comparisons made
  int          cyc;       // hang guard
  int          base;      // frame count snapshot
  // pulled-up line: released reads as one
  assign mdio = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
  mmcs_top mmcs_top_i (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regSize,
    .regRdata, .mdcIn(mdc), .mdioIn(mdio), .mdioOut, .mdioOe, .irq);
  mmcs_phy_model mmcs_phy_model_i (.run, .mdio, .mdc, .phyOe, .phyOut);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s = 2'h2);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regSize <= s;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] s = 2'h2);
    @(posedge clk);
    regAddr <= a;
    regSize <= s;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] s = 2'h2);
    rd(a, s);
    chk(v, e);
  endtask
  // run the link clock until busy drops, bounded
  task automatic waitIdle;
    int k;
    run <= 1'b1;
    repeat (2) @(posedge clk);
    for (k = 0; k < 1000; k++) begin
      rd(OFS_IND);
      if (v[IND_BUSY] === 1'b0) break;
    end
    if (k == 1000) nMismatch++;
    run <= 1'b0;
  endtask
  task automatic complete_run;
    $display("counts: %0d compared, %0d mismatched", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      complete_run;
    end
  end
  // ----
  // tests
  // ----
  initial begin
    rst = 1'b1;
    regAddr = 8'h0;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    regSize = 2'h2;
    run = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CMD, 32'h0);
    rdc(OFS_IND, 32'h0);
    rdc(8'h70, 32'h0);
    wr(OFS_IND, 32'hf);
    rdc(OFS_IND, 32'h0);
    $display("test reset values done");
    wr(OFS_ADDR, 32'h0101, SZ_BYTE);
    rdc(OFS_ADDR, 32'h0);
    wr(OFS_ADDR, 32'h0101, 2'h1);
    rdc(OFS_ADDR, 32'h0101);
    rdc(OFS_ADDR, 32'h0, SZ_BYTE);
    wr(OFS_ADDR + 8'h8, 32'h2);
    rdc(OFS_ADDR, 32'h0103);
    wr(OFS_ADDR + 8'h4, 32'h0100);
    rdc(OFS_ADDR, 32'h0003);
    wr(OFS_ADDR + 8'hc, 32'h0101);
    rdc(OFS_ADDR, 32'h0102);
    wr(OFS_ADDR, 32'h0101);
    $display("test sizes and aliases done");
    // write frame, phy status with link up
    wr(OFS_WDATA, 32'h0004);
    repeat (2) @(posedge clk);
    rdc(OFS_IND, 32'h1);
    waitIdle;
    chk({16'h0, mmcs_phy_model_i.regs[1]}, 32'h4);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_ISTAT, 32'h1);
    wr(OFS_IMASK, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    wr(OFS_ISTAT, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test write frame done");
    // single read, then link down
    wr(OFS_CMD, 32'h1);
    repeat (2) @(posedge clk);
    rdc(OFS_IND, 32'h5);
    waitIdle;
    rdc(OFS_IND, 32'h0);
    rdc(OFS_RDATA, 32'h4);
    chk(mmcs_phy_model_i.rdCnt, 32'h1);
    wr(OFS_CMD, 32'h0);
    wr(OFS_WDATA, 32'h0);
    waitIdle;
    wr(OFS_CMD, 32'h1);
    waitIdle;
    rdc(OFS_IND, 32'h8);
    rdc(OFS_RDATA, 32'h0);
    rdc(OFS_ISTAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    $display("test single read done");
    // continuous scan
    run <= 1'b1;
    wr(OFS_CMD + 8'h8, 32'h2);
    repeat (2) @(posedge clk);
    rd(OFS_IND);
    chk(v & 32'h3, 32'h3);
    repeat (1400) @(posedge clk);
    chk({31'h0, mmcs_phy_model_i.rdCnt >= 4}, 32'h1);
    wr(OFS_CMD + 8'h4, 32'h2);
    waitIdle;
    rdc(OFS_IND, 32'h8);
    rdc(OFS_CMD, 32'h1);
    wr(OFS_CMD + 8'hc, 32'h1);
    rdc(OFS_CMD, 32'h0);
    base = mmcs_phy_model_i.rdCnt;
    run <= 1'b1;
    repeat (600) @(posedge clk);
    chk({31'h0, mmcs_phy_model_i.rdCnt == base}, 32'h1);
    run <= 1'b0;
    $display("test scan done");
    complete_run;
  end
endmodule
